// ### rmpsc_dev_model.sv
// behavioural reader on the far side of the byte link: parses mode group commands
// assumes single mclk domain; tx bytes taken on txValid && txReady at mclk rise
`timescale 1ns/1ps
module rmpsc_dev_model (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady,
  output logic [7:0] rxData,
  output logic rxValid,
  input wire logic slow,
  input wire logic badMask,
  input wire logic sendRpt
);
  logic [7:0] cmd [0:6];
  logic [7:0] q [$];
  logic [7:0] modeNow, modeNew;
  logic [15:0] maskNow, maskNew, m;
  logic [31:0] cnt [0:255];
  int n, stall, frames;
  function automatic int cmd_len(input logic [7:0] c);
    case (c)
      8'h01: return 3;
      8'h03: return 4;
      8'h66: return 7;
      8'h67: return 3;
      default: return 2;
    endcase
  endfunction
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      // mode stays unset until a reset applies it, so early reads look wrong
      n = 0;
      stall = 0;
      frames = 0;
      modeNow = 8'h00;
      modeNew = 8'h00;
      maskNow = 16'h0000;
      maskNew = 16'h0000;
      q.delete();
      txReady <= 1'b0;
      rxValid <= 1'b0;
      rxData <= 8'h00;
    end else begin
      stall = stall + 1;
      txReady <= !slow || (stall % 3 == 0);
      if (txValid && txReady) begin
        cmd[n] = txData;
        n = n + 1;
        if (n >= 2 && n == cmd_len(cmd[1])) begin
          n = 0;
          case (cmd[1])
            8'h01: begin
              modeNew = cmd[2];
              q.push_back(8'h00); q.push_back(8'h02); q.push_back(cmd[2]);
            end
            8'h02: begin
              q.push_back(8'h00); q.push_back(8'h02); q.push_back(modeNow);
            end
            8'h03: begin
              maskNew = {cmd[2], cmd[3]} & rmpsc_pkg::PROTO_LEGAL;
              q.push_back(8'h00); q.push_back(8'h03);
            end
            8'h04: begin
              m = maskNow | (badMask ? 16'h0001 : 16'h0000);
              q.push_back(8'h00); q.push_back(8'h04);
              q.push_back(m[15:8]); q.push_back(m[7:0]);
            end
            8'h66: begin
              cnt[cmd[2]] = {cmd[3], cmd[4], cmd[5], cmd[6]};
              q.push_back(8'h00); q.push_back(8'h66); q.push_back(cmd[2]);
            end
            8'h67: begin
              q.push_back(8'h00); q.push_back(8'h67); q.push_back(cmd[2]);
              for (int i = 3; i >= 0; i--) q.push_back(cnt[cmd[2]][8*i+:8]);
            end
            default: begin
              modeNow = modeNew;
              maskNow = maskNew;
            end
          endcase
        end
      end
      // sendRpt marks one sync frame in which a tag is read again
      if (sendRpt) begin
        frames = frames + 1;
        if (frames >= cnt[rmpsc_pkg::SEL_6C][31:16]) begin
          frames = 0;
          q.push_back(8'h48); q.push_back(8'h00); q.push_back(8'h30); q.push_back(8'h43);
        end
      end
      // one byte every other cycle; idle line flips so a stale byte is never reread
      if (q.size() > 0 && !rxValid) begin
        rxData <= q.pop_front();
        rxValid <= 1'b1;
      end else begin
        rxData <= ~rxData;
        rxValid <= 1'b0;
      end
    end
  end
endmodule

// ### rmpsc_host.sv
// host controller for the reader mode command group: sends mode, protocol
// and seen-count commands as byte streams and checks the replies
// assumes a byte link with valid/ready out and a one-cycle rxValid strobe in
//
// What this block does
// - set mode sends 00 01 58
// - new mode needs reader reset to apply
// - get mode sends only 00 02
// - protocol mask is 16 bits, per-protocol
// - enable bits sit at fixed byte positions
// - reset reader after changing protocols
// - get protocol 00 04, reply adds mask
// - set counts: selector, seen, uniqueness, MSB first
// - selectors are 2, 3, 4, 8
// - get counts sends 00 67 selector
`timescale 1ns/1ps
module rmpsc_host #(
  parameter int TIMEOUT_CYC = rmpsc_pkg::TIMEOUT_CYC,
  parameter logic [15:0] RESET_CMD = 16'h0000
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  input wire logic [7:0] rxData,
  input wire logic rxValid
);
  rmpsc_pkg::rmpsc_state_t state_q;
  logic [2:0] op_q, idx_q;
  logic autoRst_q, chainRst_q;
  logic [31:0] toCnt_q;
  logic [15:0] protoMask_q, seenFrames_q, uniqFrames_q;
  logic [7:0] seenSel_q;
  logic [7:0] modeRd_q;
  logic [15:0] protoRd_q, seenRd_q, uniqRd_q, rptCnt_q;
  logic done_q, err_q, pendRst_q, badArg_q;
  logic [7:0] txData_q;
  logic txValid_q;
  logic [31:0] regRdata_q;
  logic [8*rmpsc_pkg::MAX_BYTES-1:0] rxBytes;
  logic [2:0] rxCnt;
  logic ctrlWr, startOk, startBad, rxDone, rspOk, timeout, isReport, collClr, sendEnd;
  logic [2:0] startOp;

  function automatic logic [7:0] cmdCode(input logic [2:0] op);
    case (op)
      rmpsc_pkg::OP_SET_MODE: cmdCode = rmpsc_pkg::CMD_SET_MODE;
      rmpsc_pkg::OP_GET_MODE: cmdCode = rmpsc_pkg::CMD_GET_MODE;
      rmpsc_pkg::OP_SET_PROTO: cmdCode = rmpsc_pkg::CMD_SET_PROTO;
      rmpsc_pkg::OP_GET_PROTO: cmdCode = rmpsc_pkg::CMD_GET_PROTO;
      rmpsc_pkg::OP_SET_SEEN: cmdCode = rmpsc_pkg::CMD_SET_SEEN;
      rmpsc_pkg::OP_GET_SEEN: cmdCode = rmpsc_pkg::CMD_GET_SEEN;
      default: cmdCode = RESET_CMD[7:0];
    endcase
  endfunction

  function automatic logic [2:0] cmdLen(input logic [2:0] op);
    case (op)
      rmpsc_pkg::OP_SET_MODE: cmdLen = 3'h3;
      rmpsc_pkg::OP_SET_PROTO: cmdLen = 3'h4;
      rmpsc_pkg::OP_SET_SEEN: cmdLen = 3'h7;
      rmpsc_pkg::OP_GET_SEEN: cmdLen = 3'h3;
      default: cmdLen = 3'h2;
    endcase
  endfunction

  function automatic logic [2:0] rspLen(input logic [2:0] op);
    case (op)
      rmpsc_pkg::OP_SET_MODE, rmpsc_pkg::OP_GET_MODE, rmpsc_pkg::OP_SET_SEEN: rspLen = 3'h3;
      rmpsc_pkg::OP_SET_PROTO: rspLen = 3'h2;
      rmpsc_pkg::OP_GET_PROTO: rspLen = 3'h4;
      rmpsc_pkg::OP_GET_SEEN: rspLen = 3'h7;
      default: rspLen = 3'h0;
    endcase
  endfunction

  function automatic logic selLegal(input logic [7:0] sel);
    selLegal = sel == rmpsc_pkg::SEL_IAG || sel == rmpsc_pkg::SEL_CVISN ||
      sel == rmpsc_pkg::SEL_T21 || sel == rmpsc_pkg::SEL_6C;
  endfunction

  // byte idx of the request for op, built from the live configuration
  function automatic logic [7:0] cmdByte(input logic [2:0] op, input logic [2:0] idx);
    logic [15:0] mask;
    mask = protoMask_q & rmpsc_pkg::PROTO_LEGAL;
    cmdByte = 8'h00;
    case (idx)
      3'h0: cmdByte = (op == rmpsc_pkg::OP_RESET) ? RESET_CMD[15:8] : rmpsc_pkg::GROUP_BYTE;
      3'h1: cmdByte = cmdCode(op);
      3'h2: begin
        if (op == rmpsc_pkg::OP_SET_MODE) begin
          cmdByte = rmpsc_pkg::MODE_88;
        end else if (op == rmpsc_pkg::OP_SET_PROTO) begin
          cmdByte = mask[15:8];
        end else begin
          cmdByte = seenSel_q;
        end
      end
      3'h3: cmdByte = (op == rmpsc_pkg::OP_SET_PROTO) ? mask[7:0] : seenFrames_q[15:8];
      3'h4: cmdByte = seenFrames_q[7:0];
      3'h5: cmdByte = uniqFrames_q[15:8];
      default: cmdByte = uniqFrames_q[7:0];
    endcase
  endfunction

  function automatic logic [7:0] rxb(input logic [2:0] i);
    rxb = rxBytes[8*i +: 8];
  endfunction

  rmpsc_rx_collect u_collect (
    .mclk(mclk),
    .arst_n(arst_n),
    .clr(collClr),
    .rxData(rxData),
    .rxValid(rxValid),
    .rxBytes(rxBytes),
    .rxCnt(rxCnt)
  );

  assign ctrlWr = regWr && regAddr == rmpsc_pkg::ADDR_CTRL && state_q == rmpsc_pkg::ST_IDLE;
  assign startOp = regWdata[rmpsc_pkg::CTRL_OP_LSB +: 3];
  assign startBad = ctrlWr && (startOp == 3'h7 ||
    ((startOp == rmpsc_pkg::OP_SET_SEEN || startOp == rmpsc_pkg::OP_GET_SEEN) &&
    !selLegal(seenSel_q)));
  assign startOk = (ctrlWr && !startBad) || chainRst_q;
  assign sendEnd = state_q == rmpsc_pkg::ST_SEND && (!txValid_q || txReady) &&
    idx_q == cmdLen(op_q);
  assign rxDone = state_q == rmpsc_pkg::ST_WAIT && rxCnt == rspLen(op_q);
  assign timeout = state_q == rmpsc_pkg::ST_WAIT && !rxDone &&
    toCnt_q == 32'(TIMEOUT_CYC - 1);
  assign isReport = state_q == rmpsc_pkg::ST_IDLE && rxCnt == 3'(rmpsc_pkg::REPORT_BYTES);
  assign collClr = startOk || rxDone || timeout || isReport;

  // reply check: group byte, command echo (02 for set mode), then the mode, selector or mask reserved bits
  always_comb begin
    rspOk = rxb(3'h0) == rmpsc_pkg::GROUP_BYTE;
    if (op_q == rmpsc_pkg::OP_SET_MODE) begin
      rspOk = rspOk && rxb(3'h1) == rmpsc_pkg::RSP_SET_MODE;
    end else begin
      rspOk = rspOk && rxb(3'h1) == cmdCode(op_q);
    end
    case (op_q)
      rmpsc_pkg::OP_SET_MODE, rmpsc_pkg::OP_GET_MODE:
        rspOk = rspOk && rxb(3'h2) == rmpsc_pkg::MODE_88;
      rmpsc_pkg::OP_SET_SEEN, rmpsc_pkg::OP_GET_SEEN:
        rspOk = rspOk && rxb(3'h2) == seenSel_q;
      rmpsc_pkg::OP_GET_PROTO:
        rspOk = rspOk && ({rxb(3'h2), rxb(3'h3)} & ~rmpsc_pkg::PROTO_LEGAL) == 16'h0000;
      default: rspOk = rspOk;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= rmpsc_pkg::ST_IDLE;
      op_q <= rmpsc_pkg::OP_SET_MODE;
      idx_q <= 3'h0;
      txData_q <= 8'h00;
      txValid_q <= 1'b0;
    end else begin
      unique case (state_q)
        rmpsc_pkg::ST_IDLE: begin
          if (startOk) begin
            state_q <= rmpsc_pkg::ST_SEND;
            op_q <= chainRst_q ? rmpsc_pkg::OP_RESET : startOp;
            idx_q <= 3'h0;
          end
        end
        rmpsc_pkg::ST_SEND: begin
          // a byte stays on the link until the device takes it
          if (!txValid_q || txReady) begin
            if (idx_q != cmdLen(op_q)) begin
              txData_q <= cmdByte(op_q, idx_q);
              txValid_q <= 1'b1;
              idx_q <= idx_q + 3'h1;
            end else begin
              txValid_q <= 1'b0;
              state_q <= (op_q == rmpsc_pkg::OP_RESET) ? rmpsc_pkg::ST_IDLE : rmpsc_pkg::ST_WAIT;
            end
          end
        end
        rmpsc_pkg::ST_WAIT: begin
          if (rxDone || timeout) begin
            state_q <= rmpsc_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      toCnt_q <= 32'h0;
    end else if (state_q == rmpsc_pkg::ST_WAIT && !rxDone) begin
      toCnt_q <= toCnt_q + 32'h1;
    end else begin
      toCnt_q <= 32'h0;
    end
  end

  // a mode or protocol change only lands after a reader reset
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pendRst_q <= 1'b0;
      chainRst_q <= 1'b0;
    end else begin
      chainRst_q <= 1'b0;
      if (rxDone && rspOk &&
          (op_q == rmpsc_pkg::OP_SET_MODE || op_q == rmpsc_pkg::OP_SET_PROTO)) begin
        pendRst_q <= 1'b1;
        chainRst_q <= autoRst_q;
      end else if (sendEnd && op_q == rmpsc_pkg::OP_RESET) begin
        pendRst_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      done_q <= 1'b0;
      err_q <= 1'b0;
      badArg_q <= 1'b0;
    end else if (startOk) begin
      done_q <= 1'b0;
      err_q <= 1'b0;
      badArg_q <= 1'b0;
    end else if (startBad) begin
      badArg_q <= 1'b1;
    end else if (rxDone || timeout || (sendEnd && op_q == rmpsc_pkg::OP_RESET)) begin
      done_q <= 1'b1;
      err_q <= timeout || (rxDone && !rspOk);
    end
  end

  // configuration is frozen while a command is on the link
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      autoRst_q <= 1'b0;
      protoMask_q <= rmpsc_pkg::PROTO_RST;
      seenSel_q <= rmpsc_pkg::SEL_RST;
      seenFrames_q <= rmpsc_pkg::COUNT_RST;
      uniqFrames_q <= rmpsc_pkg::COUNT_RST;
    end else if (regWr && state_q == rmpsc_pkg::ST_IDLE) begin
      if (regAddr == rmpsc_pkg::ADDR_CTRL) begin
        autoRst_q <= regWdata[rmpsc_pkg::CTRL_AUTORST];
      end
      if (regAddr == rmpsc_pkg::ADDR_PROTO) begin
        protoMask_q <= regWdata[15:0] & rmpsc_pkg::PROTO_LEGAL;
      end
      if (regAddr == rmpsc_pkg::ADDR_SEL) begin
        seenSel_q <= regWdata[7:0];
      end
      if (regAddr == rmpsc_pkg::ADDR_COUNTS) begin
        seenFrames_q <= regWdata[rmpsc_pkg::COUNTS_SEEN_LSB +: 16];
        uniqFrames_q <= regWdata[15:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      modeRd_q <= 8'h00;
      protoRd_q <= 16'h0000;
      seenRd_q <= 16'h0000;
      uniqRd_q <= 16'h0000;
    end else if (rxDone && rspOk) begin
      if (op_q == rmpsc_pkg::OP_GET_MODE) begin
        modeRd_q <= rxb(3'h2);
      end
      if (op_q == rmpsc_pkg::OP_GET_PROTO) begin
        protoRd_q <= {rxb(3'h2), rxb(3'h3)};
      end
      if (op_q == rmpsc_pkg::OP_GET_SEEN) begin
        seenRd_q <= {rxb(3'h3), rxb(3'h4)};
        uniqRd_q <= {rxb(3'h5), rxb(3'h6)};
      end
    end
  end

  // unsolicited seen-count reports arrive only while idle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rptCnt_q <= 16'h0000;
    end else if (isReport && {rxb(3'h0), rxb(3'h1)} == rmpsc_pkg::RPT_CODE &&
                 {rxb(3'h2), rxb(3'h3)} == rmpsc_pkg::RPT_TYPE) begin
      rptCnt_q <= rptCnt_q + 16'h1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      regRdata_q <= 32'h0;
    end else if (regRd) begin
      unique case (regAddr)
        rmpsc_pkg::ADDR_CTRL: regRdata_q <= {28'h0, autoRst_q, op_q};
        rmpsc_pkg::ADDR_PROTO: regRdata_q <= {16'h0, protoMask_q};
        rmpsc_pkg::ADDR_SEL: regRdata_q <= {24'h0, seenSel_q};
        rmpsc_pkg::ADDR_COUNTS: regRdata_q <= {seenFrames_q, uniqFrames_q};
        // a queued automatic reset counts as busy so software never sees a false idle
        rmpsc_pkg::ADDR_STATUS: regRdata_q <= {27'h0, badArg_q, pendRst_q, err_q, done_q,
          state_q != rmpsc_pkg::ST_IDLE || chainRst_q};
        rmpsc_pkg::ADDR_MODE_RD: regRdata_q <= {protoRd_q, 8'h0, modeRd_q};
        rmpsc_pkg::ADDR_SEEN_RD: regRdata_q <= {seenRd_q, uniqRd_q};
        rmpsc_pkg::ADDR_RPT: regRdata_q <= {16'h0, rptCnt_q};
        default: regRdata_q <= 32'h0;
      endcase
    end else begin
      regRdata_q <= 32'h0;
    end
  end

  assign regRdata = regRdata_q;
  assign txData = txData_q;
  assign txValid = txValid_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  sequence sSetDone;
    rxDone && rspOk && autoRst_q &&
      (op_q == rmpsc_pkg::OP_SET_MODE || op_q == rmpsc_pkg::OP_SET_PROTO);
  endsequence
  sequence sResetSent;
    ##[1:3] state_q == rmpsc_pkg::ST_SEND && op_q == rmpsc_pkg::OP_RESET;
  endsequence

  a_setmode_payload: assert property (txValid_q && op_q == rmpsc_pkg::OP_SET_MODE &&
    idx_q == 3'h3 |-> txData_q == rmpsc_pkg::MODE_88) else $error("set mode byte not 58");
  a_getmode_length: assert property (txValid_q && op_q == rmpsc_pkg::OP_GET_MODE
    |-> idx_q <= 3'h2) else $error("get mode sent too many bytes");
  a_proto_msb: assert property (txValid_q && op_q == rmpsc_pkg::OP_SET_PROTO &&
    idx_q == 3'h3 |-> txData_q == protoMask_q[15:8]) else $error("mask msb wrong");
  a_proto_reserved: assert property (txValid_q && op_q == rmpsc_pkg::OP_SET_PROTO &&
    idx_q == 3'h4 |-> (txData_q & ~rmpsc_pkg::PROTO_LEGAL[7:0]) == 8'h00)
    else $error("reserved mask bit sent");
  a_seen_order: assert property (txValid_q && txReady && op_q == rmpsc_pkg::OP_SET_SEEN &&
    idx_q == 3'h4 |=> txValid_q && txData_q == seenFrames_q[7:0]) else $error("seen lsb order");
  a_sel_legal: assert property (txValid_q && idx_q == 3'h3 &&
    (op_q == rmpsc_pkg::OP_SET_SEEN || op_q == rmpsc_pkg::OP_GET_SEEN) |-> selLegal(txData_q))
    else $error("illegal selector sent");
  a_getseen_length: assert property (txValid_q && op_q == rmpsc_pkg::OP_GET_SEEN
    |-> idx_q <= 3'h3) else $error("get counts too long");
  a_reset_follows: assert property (sSetDone |-> sResetSent)
    else $error("reset reader not issued");
  a_pending_hold: assert property (pendRst_q && !(sendEnd && op_q == rmpsc_pkg::OP_RESET)
    |=> pendRst_q) else $error("pending reset lost");
  a_readback_mask: assert property (rxDone && rspOk && op_q == rmpsc_pkg::OP_GET_PROTO
    |=> protoRd_q == $past({rxb(3'h2), rxb(3'h3)})) else $error("mask readback wrong");
  a_tx_hold: assert property (txValid_q && !txReady |=> txValid_q && $stable(txData_q))
    else $error("tx byte changed while stalled");
endmodule

// ### rmpsc_pkg.sv
// constants for the reader mode / protocol / seen-count host controller
// assumes one 20 MHz clock; shared by the controller and its receive collector
package rmpsc_pkg;
  // command bytes of the mode command group
  localparam logic [7:0] GROUP_BYTE = 8'h00;
  localparam logic [7:0] CMD_SET_MODE = 8'h01;
  localparam logic [7:0] CMD_GET_MODE = 8'h02;
  localparam logic [7:0] RSP_SET_MODE = 8'h02;
  localparam logic [7:0] CMD_SET_PROTO = 8'h03;
  localparam logic [7:0] CMD_GET_PROTO = 8'h04;
  localparam logic [7:0] CMD_SET_SEEN = 8'h66;
  localparam logic [7:0] CMD_GET_SEEN = 8'h67;
  localparam logic [7:0] MODE_88 = 8'h58;
  // protocol enable bitmask
  localparam logic [15:0] PROTO_6C = 16'h0800;
  localparam logic [15:0] PROTO_CVISN = 16'h0200;
  localparam logic [15:0] PROTO_IAG = 16'h0100;
  localparam logic [15:0] PROTO_IAG_READ = 16'h0080;
  localparam logic [15:0] PROTO_T21 = 16'h0008;
  localparam logic [15:0] PROTO_LEGAL =
    PROTO_6C | PROTO_CVISN | PROTO_IAG | PROTO_IAG_READ | PROTO_T21;
  // counter protocol selectors
  localparam logic [7:0] SEL_IAG = 8'h02;
  localparam logic [7:0] SEL_CVISN = 8'h03;
  localparam logic [7:0] SEL_T21 = 8'h04;
  localparam logic [7:0] SEL_6C = 8'h08;
  // asynchronous seen-count report header
  localparam logic [15:0] RPT_CODE = 16'h4800;
  localparam logic [15:0] RPT_TYPE = 16'h3043;
  // software register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PROTO = 8'h04;
  localparam logic [7:0] ADDR_SEL = 8'h08;
  localparam logic [7:0] ADDR_COUNTS = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_MODE_RD = 8'h14;
  localparam logic [7:0] ADDR_SEEN_RD = 8'h18;
  localparam logic [7:0] ADDR_RPT = 8'h1c;
  // field positions
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_AUTORST = 3;
  localparam int COUNTS_SEEN_LSB = 16;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;
  localparam int ST_PEND = 3;
  localparam int ST_BADARG = 4;
  // reset values
  localparam logic [15:0] PROTO_RST = 16'h0000;
  localparam logic [7:0] SEL_RST = 8'h08;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  // operations in the control register
  localparam logic [2:0] OP_SET_MODE = 3'h0;
  localparam logic [2:0] OP_GET_MODE = 3'h1;
  localparam logic [2:0] OP_SET_PROTO = 3'h2;
  localparam logic [2:0] OP_GET_PROTO = 3'h3;
  localparam logic [2:0] OP_SET_SEEN = 3'h4;
  localparam logic [2:0] OP_GET_SEEN = 3'h5;
  localparam logic [2:0] OP_RESET = 3'h6;
  localparam int MAX_BYTES = 7;
  localparam int REPORT_BYTES = 4;
  // response time-out
  localparam int CLK_MHZ = 20;
  localparam int TIMEOUT_US = 1000;
  localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;
  typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_WAIT} rmpsc_state_t;
endpackage

// ### rmpsc_rx_collect.sv
// receive byte collector: stores up to seven reply bytes in arrival order
// assumes rxValid is a one-cycle strobe synchronous to mclk
`timescale 1ns/1ps
module rmpsc_rx_collect (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic clr,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  output logic [8*rmpsc_pkg::MAX_BYTES-1:0] rxBytes,
  output logic [2:0] rxCnt
);
  logic [7:0] store_q [rmpsc_pkg::MAX_BYTES];
  logic [2:0] cnt_q;

  // a byte landing in a clearing cycle is dropped; frames never overlap a clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 3'h0;
    end else if (clr) begin
      cnt_q <= 3'h0;
    end else if (rxValid && cnt_q < 3'(rmpsc_pkg::MAX_BYTES)) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < rmpsc_pkg::MAX_BYTES; i++) begin
        store_q[i] <= 8'h00;
      end
    end else if (!clr && rxValid && cnt_q < 3'(rmpsc_pkg::MAX_BYTES)) begin
      store_q[cnt_q] <= rxData;
    end
  end

  always_comb begin
    for (int i = 0; i < rmpsc_pkg::MAX_BYTES; i++) begin
      rxBytes[8*i +: 8] = store_q[i];
    end
  end
  assign rxCnt = cnt_q;
endmodule

// ### test_reader_mode_protocol_seen_cfg.sv
// self-checking bench for the mode group host controller
// assumes the device model answers every command except the reset reader one
`timescale 1ns/1ps
module test_reader_mode_protocol_seen_cfg;
  logic mclk, arst_n, regWr, regRd, txReady, rxValid, txValid, slow, badMask, sendRpt;
  logic [7:0] regAddr, txData, rxData;
  logic [31:0] regWdata, regRdata, d;
  int failures, checks, cyc;
  rmpsc_host #(.TIMEOUT_CYC(50)) u_rmpsc_host (.mclk(mclk), .arst_n(arst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .txData(txData), .txValid(txValid), .txReady(txReady),
    .rxData(rxData), .rxValid(rxValid));
  rmpsc_dev_model u_rmpsc_dev_model (.mclk(mclk), .arst_n(arst_n), .txData(txData),
    .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxValid(rxValid),
    .slow(slow), .badMask(badMask), .sendRpt(sendRpt));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // long enough for every command with the slow link plus margin
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    regWr <= 1'b1; regAddr <= a; regWdata <= v;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    regRd <= 1'b1; regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask
  // start an operation, wait until idle, compare the masked status
  task automatic op(input logic [31:0] ctl, input logic [4:0] msk, input logic [4:0] exp);
    int k;
    wr(rmpsc_pkg::ADDR_CTRL, ctl);
    k = 0;
    do begin
      rd(rmpsc_pkg::ADDR_STATUS, d);
      k++;
    end while (d[0] !== 1'b0 && k < 300);
    // a command that never goes idle counts as a mismatch here
    chk({31'h0, d[0]}, 32'h0);
    chk({27'h0, d[4:0] & msk}, {27'h0, exp});
  endtask
  initial begin
    logic [7:0] sel [4];
    sel = '{8'h02, 8'h03, 8'h04, 8'h08};
    {regWr, regRd, slow, badMask, sendRpt} = 5'h00;
    regAddr = 8'h00; regWdata = 32'h0; failures = 0; checks = 0; cyc = 0;
    arst_n = 1'b0;
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    rd(rmpsc_pkg::ADDR_PROTO, d); chk(d, 32'h0);
    rd(rmpsc_pkg::ADDR_SEL, d); chk(d, 32'h8);
    rd(8'h20, d); chk(d, 32'h0);
    op(32'h0, 5'h1f, 5'h0a);
    op(32'h1, 5'h0e, 5'h0e);
    op(32'h6, 5'h08, 5'h00);
    op(32'h1, 5'h1f, 5'h02);
    rd(rmpsc_pkg::ADDR_MODE_RD, d); chk({24'h0, d[7:0]}, 32'h58);
    $display("test mode done");
    slow <= 1'b1;
    wr(rmpsc_pkg::ADDR_PROTO, 32'hffff);
    rd(rmpsc_pkg::ADDR_PROTO, d); chk(d, 32'h0b88);
    wr(rmpsc_pkg::ADDR_PROTO, 32'h0808);
    op(32'h2, 5'h1f, 5'h0a);
    op(32'h3, 5'h06, 5'h02);
    rd(rmpsc_pkg::ADDR_MODE_RD, d); chk({16'h0, d[31:16]}, 32'h0);
    op(32'h6, 5'h08, 5'h00);
    op(32'h3, 5'h1f, 5'h02);
    rd(rmpsc_pkg::ADDR_MODE_RD, d); chk({16'h0, d[31:16]}, 32'h0808);
    wr(rmpsc_pkg::ADDR_PROTO, 32'h0);
    op(32'ha, 5'h1e, 5'h02);
    badMask <= 1'b1;
    op(32'h3, 5'h06, 5'h06);
    badMask <= 1'b0;
    op(32'h3, 5'h1f, 5'h02);
    rd(rmpsc_pkg::ADDR_MODE_RD, d); chk({16'h0, d[31:16]}, 32'h0);
    $display("test protocol done");
    slow <= 1'b0;
    foreach (sel[i]) begin
      wr(rmpsc_pkg::ADDR_SEL, {24'h0, sel[i]});
      wr(rmpsc_pkg::ADDR_COUNTS, {8'h12, sel[i], 8'h34, sel[i] + 8'h01});
      op(32'h4, 5'h1f, 5'h02);
    end
    foreach (sel[i]) begin
      wr(rmpsc_pkg::ADDR_SEL, {24'h0, sel[i]});
      op(32'h5, 5'h1f, 5'h02);
      rd(rmpsc_pkg::ADDR_SEEN_RD, d); chk(d, {8'h12, sel[i], 8'h34, sel[i] + 8'h01});
    end
    wr(rmpsc_pkg::ADDR_SEL, 32'h5);
    op(32'h4, 5'h11, 5'h10);
    op(32'h7, 5'h11, 5'h10);
    $display("test counters done");
    wr(rmpsc_pkg::ADDR_SEL, 32'h8);
    wr(rmpsc_pkg::ADDR_COUNTS, 32'h00020005);
    op(32'h4, 5'h1f, 5'h02);
    repeat (4) begin
      @(posedge mclk);
      sendRpt <= 1'b1;
      @(posedge mclk);
      sendRpt <= 1'b0;
      repeat (12) @(posedge mclk);
    end
    rd(rmpsc_pkg::ADDR_RPT, d); chk(d, 32'h2);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    rd(rmpsc_pkg::ADDR_RPT, d); chk(d, 32'h0);
    rd(rmpsc_pkg::ADDR_COUNTS, d); chk(d, 32'h0);
    $display("test report done");
    stop_test();
  end
endmodule
